/* File: design/mqr_pkg.sv */
// Shared constants and types for the multi-I/O fast read engine, plus the
// link front end that brings the host's select, clock and IO lines in.
// Assumes one system clock (clk_in) that runs at least eight times faster
// than the host serial clock, and a synchronous active-low reset.

package mqr_pkg;
    // Instruction codes handled by the read path
    localparam logic [7:0] MQR_OPC_DUAL_DTR = 8'hbd;
    localparam logic [7:0] MQR_OPC_QUAD     = 8'heb;
    localparam logic [7:0] MQR_OPC_QUAD_DTR = 8'hed;
    // Field sizes, in bits
    localparam logic [4:0] MQR_CMD_BITS  = 5'h08;
    localparam logic [4:0] MQR_ADDR_BITS = 5'h18;
    localparam logic [4:0] MQR_MODE_BITS = 5'h08;
    // Continuous read: select pair value that keeps the mode
    localparam logic [1:0] MQR_CONT_KEEP = 2'h2;
    // Dummy clocks in single-line command mode
    localparam logic [3:0] MQR_SPI_DUMMY_QUAD     = 4'h4;
    localparam logic [3:0] MQR_SPI_DUMMY_QUAD_DTR = 4'h4;
    localparam logic [3:0] MQR_SPI_DUMMY_DUAL_DTR = 4'h4;
    // Four-wire mode: dummy = base + 2 * select, mode clocks counted in it
    localparam logic [3:0] MQR_QPI_DUMMY_BASE    = 4'h2;
    localparam logic [3:0] MQR_QPI_MODE_CLK_SDR  = 4'h2;
    localparam logic [3:0] MQR_QPI_MODE_CLK_DTR  = 4'h1;
    // Reset values of the configuration bits {W6,W5,W4} and of the four-wire dummy select
    localparam logic [2:0] MQR_WRAP_RESET      = 3'h7;
    localparam logic [1:0] MQR_DUMMY_SEL_RESET = 2'h0;
    // Smallest wrap section, in bytes
    localparam logic [7:0] MQR_WRAP_MIN_LEN = 8'h08;
    // Lane masks for the output enables (low = driving)
    localparam logic [3:0] MQR_OE_QUAD = 4'h0;
    localparam logic [3:0] MQR_OE_DUAL = 4'hc;
    localparam logic [3:0] MQR_OE_OFF  = 4'hf;

    // Transaction phase, one-hot
    typedef enum logic [6:0] {
        MQR_S_IDLE  = 7'h01,
        MQR_S_CMD   = 7'h02,
        MQR_S_ADDR  = 7'h04,
        MQR_S_MODE  = 7'h08,
        MQR_S_DUMMY = 7'h10,
        MQR_S_DATA  = 7'h20,
        MQR_S_IGN   = 7'h40
    } mqr_state_t;

    // Read flavour being served
    typedef enum logic [1:0] {
        MQR_OP_NONE     = 2'h0,
        MQR_OP_DUAL_DTR = 2'h1,
        MQR_OP_QUAD     = 2'h2,
        MQR_OP_QUAD_DTR = 2'h3
    } mqr_op_t;
endpackage

/* File: design/mqr_link_sync.sv */
// Link front end: two-flop synchronisers on select, serial clock and IO,
// and edge pulses of the serial clock taken from the synchronised copy.
// Assumes select, serial clock and IO are asynchronous pins from the host.

`timescale 1ns/10ps

module mqr_link_sync
    import mqr_pkg::*;
(
    input  wire logic       clk_in,      // System clock
    input  wire logic       nrst_in,     // Synchronous reset, active low
    input  wire logic       cs_n_in,     // Select pin, active low
    input  wire logic       sck_in,      // Host serial clock pin
    input  wire logic [3:0] io_in,       // IO pins
    output logic            cs_n_out,    // Synchronised select
    output logic            rise_out,    // One-cycle pulse per rising edge
    output logic            fall_out,    // One-cycle pulse per falling edge
    output logic [3:0]      io_out       // Synchronised IO
);
    // Three stages; only stage two and three feed logic
    typedef struct packed {
        logic [5:0] s1;                  // First flop, read by s2 only
        logic [5:0] s2;                  // Second flop
        logic [5:0] s3;                  // Edge history of s2
    } mqr_sync_t;

    mqr_sync_t r_q;                      // Registered state
    mqr_sync_t r_d;                      // Next state

    // Shift the pins through the chain; select idles high
    always_comb
    begin
        r_d    = r_q;
        r_d.s1 = {cs_n_in, sck_in, io_in};
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
    end

    // Register stage
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            r_q <= {3{6'h20}};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign cs_n_out = r_q.s2[5];
    assign io_out   = r_q.s2[3:0];
    assign rise_out = r_q.s2[4] & ~r_q.s3[4];
    assign fall_out = ~r_q.s2[4] & r_q.s3[4];
endmodule

/* File: design/mqr_read_engine.sv */
// Read-path command engine of a serial NOR flash: dual DTR I/O read, quad
// I/O read and quad DTR I/O read, with continuous read and wrapped bursts.
// Assumes the array answers mem_data_in one system clock after
// mem_addr_out changes, and the serial clock is at most clk_in / 8.
// Notes on behaviour
// - Dual DTR read takes address two bits
// - Mode byte follows address; low nibble ignored
// - Select pair 10 skips next opcode
// - Any other pair restores full opcode
// - Quad read on four lines, four dummies
// - Quad reads need quad permit bit set
// - Wrap setting governs single-line quad reads
// - Wrap inside aligned section until select rises
// - Wrap bits: disable plus length select
// - Four-wire DTR: mode bits count as dummy
// - Continuous read also in four-wire mode
// - No wrap in four-wire mode
// - DTR samples and drives both edges
// - Rise sampling, fall output, MSB first
// - Four-wire dummies 2/4/6/8, reset 2
// - Wrap disable bit resets to one

`timescale 1ns/10ps

module mqr_read_engine
    import mqr_pkg::*;
(
    input  wire logic        clk_in,                      // System clock, 10 MHz
    input  wire logic        nrst_in,                     // Synchronous reset, active low
    input  wire logic        cs_n_in,                     // Host select pin, active low
    input  wire logic        sck_in,                      // Host serial clock pin
    input  wire logic [3:0]  io_in,                       // IO pins, input side
    output logic      [3:0]  io_out,                      // IO pins, output side
    output logic      [3:0]  io_oe_n_out,                 // IO enables, low drives
    output logic      [23:0] mem_addr_out,                // Array byte address
    input  wire logic [7:0]  mem_data_in,                 // Array byte
    input  wire logic        quad_lines_permit_bit_in,    // Quad permit status bit
    input  wire logic        four_wire_command_mode_in,   // Four-wire command mode
    input  wire logic        wrap_load_in,                // Pulse: load wrap bits
    input  wire logic [2:0]  wrap_setting_bits_in,        // {W6,W5,W4} to load
    input  wire logic        dummy_load_in,               // Pulse: load dummy select
    input  wire logic [1:0]  dummy_select_in,             // Dummy select to load
    output logic      [2:0]  wrap_setting_bits_out,       // Current wrap bits
    output logic             continuous_read_out,         // Opcode skip armed
    output logic             read_active_out              // Read in progress
);
    // All engine state
    typedef struct packed {
        mqr_state_t  st;       // Phase
        mqr_op_t     op;       // Active read flavour
        logic [7:0]  cmd;      // Opcode shifter
        logic [4:0]  cnt;      // Bits received, or dummies left
        logic [23:0] addr;     // Address / output pointer
        logic [7:0]  mode;     // Continuous read bits
        logic        cont;     // Opcode skip armed
        mqr_op_t     cont_op;  // Flavour to repeat
        logic [1:0]  idx;      // Slice within the current byte
        logic [3:0]  io;       // Output lanes
        logic [3:0]  oe_n;     // Output enables
        logic [2:0]  wrap;     // {W6,W5,W4}
        logic [1:0]  dsel;     // Four-wire dummy select
    } mqr_eng_t;

    mqr_eng_t r_q;             // Registered state
    mqr_eng_t r_d;             // Next state

    logic       cs_n_s;        // Synchronised select
    logic       rise_s;        // Serial clock rising edge
    logic       fall_s;        // Serial clock falling edge
    logic [3:0] io_s;          // Synchronised IO

    // Pin synchronisers and edge finders
    mqr_link_sync u_sync (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .cs_n_in  (cs_n_in),
        .sck_in   (sck_in),
        .io_in    (io_in),
        .cs_n_out (cs_n_s),
        .rise_out (rise_s),
        .fall_out (fall_s),
        .io_out   (io_s)
    );

    logic       quad;          // Four lanes in use
    logic       dtr;           // Double-edge flavour
    logic [4:0] lanes;         // Bits per sample
    logic       samp;          // Sample event for address and mode
    logic       wrap_on;       // Wrap applies to this read
    logic [7:0] wmask;         // Offset mask within wrap section
    logic [7:0] next_lo;       // Low address byte after increment
    logic [7:0] sh;            // Byte aligned to current slice
    logic [3:0] dummies;       // Dummy clocks after the mode bits
    logic [7:0] opc;           // Opcode once complete
    mqr_op_t    dec;           // Decoded flavour

    // Flavour properties and helpers
    always_comb
    begin
        quad  = (r_q.op == MQR_OP_QUAD) || (r_q.op == MQR_OP_QUAD_DTR);
        dtr   = (r_q.op == MQR_OP_DUAL_DTR) || (r_q.op == MQR_OP_QUAD_DTR);
        lanes = quad ? 5'h04 : 5'h02;
        samp  = rise_s || (dtr && fall_s);
        // Wrap only for quad reads issued in single-line mode
        wrap_on = quad && !r_q.wrap[0] && !four_wire_command_mode_in;
        wmask   = 8'((MQR_WRAP_MIN_LEN << r_q.wrap[2:1]) - 8'h01);
        next_lo = (r_q.addr[7:0] & ~wmask) | ((r_q.addr[7:0] + 8'h01) & wmask);
        if (!wrap_on)
        begin
            next_lo = r_q.addr[7:0] + 8'h01;
        end
        // Slice select, most significant first
        if (quad)
        begin
            sh = r_q.idx[0] ? {mem_data_in[3:0], 4'h0} : mem_data_in;
        end
        else
        begin
            sh = mem_data_in << {r_q.idx, 1'b0};
        end
        // Dummies; in four-wire mode the mode clocks are part of the count
        if (four_wire_command_mode_in)
        begin
            dummies = 4'(MQR_QPI_DUMMY_BASE + {1'b0, r_q.dsel, 1'b0}
                      - (dtr ? MQR_QPI_MODE_CLK_DTR : MQR_QPI_MODE_CLK_SDR));
        end
        else if (r_q.op == MQR_OP_QUAD)
        begin
            dummies = MQR_SPI_DUMMY_QUAD;
        end
        else if (r_q.op == MQR_OP_QUAD_DTR)
        begin
            dummies = MQR_SPI_DUMMY_QUAD_DTR;
        end
        else
        begin
            dummies = MQR_SPI_DUMMY_DUAL_DTR;
        end
        // Opcode decode; quad reads need the permit bit
        opc = four_wire_command_mode_in ? {r_q.cmd[3:0], io_s} : {r_q.cmd[6:0], io_s[0]};
        dec = MQR_OP_NONE;
        if (opc == MQR_OPC_DUAL_DTR && !four_wire_command_mode_in)
        begin
            dec = MQR_OP_DUAL_DTR;
        end
        else if (opc == MQR_OPC_QUAD && quad_lines_permit_bit_in)
        begin
            dec = MQR_OP_QUAD;
        end
        else if (opc == MQR_OPC_QUAD_DTR && quad_lines_permit_bit_in)
        begin
            dec = MQR_OP_QUAD_DTR;
        end
    end

    // Phase sequencing and datapath
    always_comb
    begin
        r_d = r_q;
        // Configuration loads; reset values hold until loaded
        if (wrap_load_in)
        begin
            r_d.wrap = wrap_setting_bits_in;
        end
        if (dummy_load_in)
        begin
            r_d.dsel = dummy_select_in;
        end
        if (cs_n_s)
        begin
            // Select high ends every phase and floats the lanes
            r_d.st   = MQR_S_IDLE;
            r_d.oe_n = MQR_OE_OFF;
            r_d.idx  = 2'h0;
        end
        else
        begin
            case (r_q.st)
                MQR_S_IDLE:
                begin
                    r_d.cnt = 5'h00;
                    r_d.cmd = 8'h00;
                    if (r_q.cont)
                    begin
                        // Opcode skipped: address entry starts at once
                        r_d.op = r_q.cont_op;
                        r_d.st = MQR_S_ADDR;
                    end
                    else
                    begin
                        r_d.st = MQR_S_CMD;
                    end
                end
                MQR_S_CMD:
                begin
                    // Opcode is always single-edge, rising
                    if (rise_s)
                    begin
                        r_d.cmd = opc;
                        r_d.cnt = r_q.cnt + (four_wire_command_mode_in ? 5'h04 : 5'h01);
                        if (r_d.cnt == MQR_CMD_BITS)
                        begin
                            r_d.op  = dec;
                            r_d.cnt = 5'h00;
                            r_d.st  = (dec == MQR_OP_NONE) ? MQR_S_IGN : MQR_S_ADDR;
                        end
                    end
                end
                MQR_S_ADDR:
                begin
                    if (samp)
                    begin
                        r_d.addr = quad ? {r_q.addr[19:0], io_s} : {r_q.addr[21:0], io_s[1:0]};
                        r_d.cnt  = r_q.cnt + lanes;
                        if (r_d.cnt == MQR_ADDR_BITS)
                        begin
                            r_d.cnt = 5'h00;
                            r_d.st  = MQR_S_MODE;
                        end
                    end
                end
                MQR_S_MODE:
                begin
                    if (samp)
                    begin
                        r_d.mode = quad ? {r_q.mode[3:0], io_s} : {r_q.mode[5:0], io_s[1:0]};
                        r_d.cnt  = r_q.cnt + lanes;
                        if (r_d.cnt == MQR_MODE_BITS)
                        begin
                            // Only the select pair decides the next frame
                            r_d.cont    = (r_d.mode[5:4] == MQR_CONT_KEEP);
                            r_d.cont_op = r_q.op;
                            r_d.cnt     = {1'b0, dummies};
                            r_d.st      = MQR_S_DUMMY;
                        end
                    end
                end
                MQR_S_DUMMY:
                begin
                    // Lanes stay floating; the host must have let go too
                    if (fall_s)
                    begin
                        if (r_q.cnt == 5'h00)
                        begin
                            r_d.io   = quad ? sh[7:4] : {2'h0, sh[7:6]};
                            r_d.oe_n = quad ? MQR_OE_QUAD : MQR_OE_DUAL;
                            r_d.idx  = 2'h1;
                            r_d.st   = MQR_S_DATA;
                        end
                        else
                        begin
                            r_d.cnt = r_q.cnt - 5'h01;
                        end
                    end
                end
                MQR_S_DATA:
                begin
                    // Single-edge drives on fall, double-edge on both
                    if (fall_s || (dtr && rise_s))
                    begin
                        r_d.io  = quad ? sh[7:4] : {2'h0, sh[7:6]};
                        r_d.idx = r_q.idx + 2'h1;
                        if (r_q.idx == (quad ? 2'h1 : 2'h3))
                        begin
                            r_d.idx  = 2'h0;
                            // Without wrap the whole pointer carries across pages
                            r_d.addr = wrap_on ? {r_q.addr[23:8], next_lo}
                                               : r_q.addr + 24'h000001;
                        end
                    end
                end
                MQR_S_IGN:
                begin
                    r_d.st = MQR_S_IGN;
                end
                default:
                begin
                    r_d.st = MQR_S_IDLE;
                end
            endcase
            // Pointer leads the lanes by one slice; advance it after the last
            if (r_q.st == MQR_S_DATA && r_d.idx == 2'h0 && r_q.idx != 2'h0)
            begin
                r_d.idx = 2'h0;
            end
        end
    end

    // Register stage
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            r_q      <= '0;
            r_q.st   <= MQR_S_IDLE;
            r_q.oe_n <= MQR_OE_OFF;
            r_q.wrap <= MQR_WRAP_RESET;
            r_q.dsel <= MQR_DUMMY_SEL_RESET;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign io_out                = r_q.io;
    assign io_oe_n_out           = r_q.oe_n;
    assign mem_addr_out          = r_q.addr;
    assign wrap_setting_bits_out = r_q.wrap;
    assign continuous_read_out   = r_q.cont;
    assign read_active_out       = !r_q.st[0];

    // Checks on the engine's own behaviour
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    chk_oe_data_only: assert property (io_oe_n_out != MQR_OE_OFF |-> r_q.st == MQR_S_DATA)
        else $error("IO driven outside data phase");
    chk_cs_floats_io: assert property (cs_n_s |=> io_oe_n_out == MQR_OE_OFF)
        else $error("IO still driven after select high");
    chk_cont_arm: assert property (r_q.st == MQR_S_MODE && r_d.st == MQR_S_DUMMY && r_d.mode[5:4] == 2'h2 |=> continuous_read_out)
        else $error("Continuous read not armed");
    chk_cont_drop: assert property (r_q.st == MQR_S_MODE && r_d.st == MQR_S_DUMMY && r_d.mode[5:4] != 2'h2 |=> !continuous_read_out)
        else $error("Continuous read not dropped");
    chk_skip_opcode: assert property (r_q.st == MQR_S_IDLE && !cs_n_s && r_q.cont |=> r_q.st == MQR_S_ADDR)
        else $error("Opcode not skipped");
    chk_quad_permit: assert property (r_q.st == MQR_S_CMD && r_d.st == MQR_S_ADDR && r_d.op != MQR_OP_DUAL_DTR |-> quad_lines_permit_bit_in)
        else $error("Quad read accepted without permit");
    chk_wrap_bound: assert property (r_q.st == MQR_S_DATA && wrap_on && $changed(r_q.addr) |-> r_q.addr[23:6] == $past(r_q.addr[23:6]))
        else $error("Wrapped burst left its section");
    chk_no_wrap_qpi: assert property (four_wire_command_mode_in |-> !wrap_on)
        else $error("Wrap active in four-wire mode");
    chk_wrap_reset: assert property (@(posedge clk_in) disable iff (1'b0) !nrst_in |=> wrap_setting_bits_out[0])
        else $error("Wrap disable bit not set by reset");
    chk_dummy_reset: assert property (@(posedge clk_in) disable iff (1'b0) !nrst_in |=> r_q.dsel == 2'h0)
        else $error("Dummy select not reset to two clocks");
endmodule

/* File: verification/mqr_host_model.sv */
// Host controller model for the read engine: select, serial clock and IO.
// Assumes the bench clock; serial clock idles low, half period four clk_in cycles.
`timescale 1ns/10ps
module mqr_host_model (
    input  wire logic [3:0] io_in,      // Resolved IO lines
    input  wire logic [3:0] oe_n_in,    // Device enables, low drives
    input  wire logic       clk_in,     // Bench clock
    output logic            cs_n_out,   // Select, active low
    output logic            sck_out,    // Serial clock, still between frames
    output logic [3:0]      io_out,     // Host IO values
    output logic [3:0]      io_en_out   // Host IO enables, high drives
);
    logic [7:0] rx [64];  // Bytes read back in order
    logic       drove;    // Device enabled a lane this frame
    initial
    begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        io_out = 4'h0;
        io_en_out = 4'h0;
        drove = 1'b0;
    end
    // Half of the serial clock period
    task automatic half_period();
        repeat (4) @(posedge clk_in);
    endtask
    // One serial clock: set IO while low, rise, sample just before the fall
    task automatic cyc(input logic [3:0] v, input logic [3:0] en, output logic [3:0] s);
        io_out <= v;
        io_en_out <= en;
        half_period();
        sck_out <= 1'b1;
        half_period();
        s = io_in;
        drove = drove | (oe_n_in != 4'hf);
        sck_out <= 1'b0;
    endtask
    // Release IO, then raise select and keep it high long enough
    task automatic deselect();
        io_en_out <= 4'h0;
        half_period();
        cs_n_out <= 1'b1;
        repeat (2) half_period();
    endtask
    // Quad read frame; opcode left out while the device skips it
    task automatic frame(input bit skip, input bit four_wire_command_mode, input logic [7:0] opc, input logic [23:0] a,
                         input logic [7:0] m, input int ndum, input int nby);
        logic [3:0] s;
        drove = 1'b0;
        cs_n_out <= 1'b0;
        half_period();
        if (!skip && four_wire_command_mode)
        begin
            cyc(opc[7:4], 4'hf, s);
            cyc(opc[3:0], 4'hf, s);
        end
        else if (!skip)
            for (int i = 7; i >= 0; i--) cyc({3'h0, opc[i]}, 4'h1, s);
        for (int i = 5; i >= 0; i--) cyc(a[i*4+:4], 4'hf, s);
        cyc(m[7:4], 4'hf, s);
        cyc(m[3:0], 4'hf, s);
        repeat (ndum) cyc(4'h0, 4'h0, s);
        for (int i = 0; i < 2 * nby; i++)
        begin
            cyc(4'h0, 4'h0, s);
            rx[i/2] = {rx[i/2][3:0], s};
        end
        deselect();
    endtask
    // Exit from continuous mode: ones on IO0, other lanes left floating
    task automatic ones(input int n);
        logic [3:0] s;
        cs_n_out <= 1'b0;
        half_period();
        repeat (n) cyc(4'h1, 4'h1, s);
        deselect();
    endtask
endmodule

/* File: verification/tb_multi_io_fast_read_engine.sv */
// Testbench of the read engine: host model on the link, array as a function.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/10ps
module tb_multi_io_fast_read_engine;
    import mqr_pkg::*;
    logic        clk_in = 1'b0;      // System clock
    logic        nrst_in = 1'b0;     // Reset, active low
    logic        cs_n, sck, cont, act, drv;  // Link and status
    logic [3:0]  h_io, h_en, d_io, d_oe_n, io;  // IO parties and wire
    logic [3:0]  pat = 4'h0;         // Floating lines keep changing
    logic [23:0] mem_addr;           // Array address
    logic        permit = 1'b1, four_wire_command_mode = 1'b0, wload = 1'b0, dload = 1'b0;
    logic [2:0]  wbits = 3'h7, wcur; // Wrap bits in and out
    logic [1:0]  dsel = 2'h0;        // Dummy select
    bit          arm = 1'b0;         // Expected opcode skip
    logic [31:0] seed = 32'hfe91f682;  // Xorshift state
    int          fail_count = 0, check_count = 0;
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) pat <= pat + 4'h5;
    // Wire level from every party's enable
    assign io = (~d_oe_n & d_io) | (d_oe_n & h_en & h_io) | (d_oe_n & ~h_en & pat);
    assign drv = host.drove;
    mqr_host_model host (.io_in(io), .oe_n_in(d_oe_n), .clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck),
        .io_out(h_io), .io_en_out(h_en));
    mqr_read_engine dut (.clk_in(clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n), .sck_in(sck), .io_in(io),
        .io_out(d_io), .io_oe_n_out(d_oe_n), .mem_addr_out(mem_addr), .mem_data_in(mf(mem_addr)),
        .quad_lines_permit_bit_in(permit), .four_wire_command_mode_in(four_wire_command_mode), .wrap_load_in(wload),
        .wrap_setting_bits_in(wbits), .dummy_load_in(dload), .dummy_select_in(dsel),
        .wrap_setting_bits_out(wcur), .continuous_read_out(cont), .read_active_out(act));
    // Array contents, distinct per address within each 256-byte page
    function automatic logic [7:0] mf(logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
    endfunction
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Address of byte i, wrapped inside its section when wrap applies
    function automatic logic [23:0] ea(logic [23:0] a, int i, logic [2:0] w, logic q);
        logic [23:0] len;
        len = 24'h8 << w[2:1];
        if (w[0] || q) return a + 24'(i);
        return (a & ~(len - 24'h1)) | ((a + 24'(i)) & (len - 24'h1));
    endfunction
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Bounded wait for the engine to go idle
    task automatic wait_idle();
        for (int k = 0; k < 20 && act !== 1'b0; k++) @(posedge clk_in);
        check("idle", act, 1'b0);
        if (act !== 1'b0) finish_test();
    endtask
    // Load wrap bits and dummy select with one-cycle pulses
    task automatic cfg(logic [2:0] w, logic [1:0] s);
        @(posedge clk_in);
        wbits <= w;
        dsel <= s;
        wload <= 1'b1;
        dload <= 1'b1;
        @(posedge clk_in);
        wload <= 1'b0;
        dload <= 1'b0;
        @(posedge clk_in);
        check("wrap bits", wcur, w);
    endtask
    // Quad read of n bytes, expectations from the bench's own settings
    task automatic rd(logic [23:0] a, logic [7:0] m, int n);
        host.frame(arm, four_wire_command_mode, MQR_OPC_QUAD, a, m, four_wire_command_mode ? 2 * int'(dsel) : 4, n);
        wait_idle();
        for (int i = 0; i < n; i++) check("data", host.rx[i], mf(ea(a, i, wbits, four_wire_command_mode)));
        arm = (m[5:4] == 2'b10);
        check("cont", cont, arm);
        check("lanes", d_oe_n, 4'hf);
    endtask
    initial
    begin
        logic [31:0] r;
        logic [7:0]  bad [3];
        bad = '{8'heb, 8'hed, 8'h3c};
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        check("wrap reset", wcur, 3'h7);
        check("cont reset", cont, 1'b0);
        repeat (4) @(posedge clk_in);
        rd(24'hfffffe, 8'h00, 4);
        rd(24'h000123, 8'ha5, 3);
        rd(24'h0003f9, 8'h20, 9);
        host.ones(8);
        wait_idle();
        check("exit", cont, 1'b0);
        arm = 1'b0;
        $display("test corner reads done");
        for (int k = 0; k < 8; k++)
        begin
            r = xs();
            cfg(r[2:0], 2'h0);
            r = xs();
            rd(r[23:0], r[31:24], 8 + int'(r[27:24]));
        end
        rd(24'h0, 8'h00, 1);
        $display("test random reads done");
        permit <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            host.frame(1'b0, 1'b0, bad[k], 24'h0, 8'h20, 0, 0);
            wait_idle();
            check("refused", drv, 1'b0);
            check("cont kept", cont, 1'b0);
        end
        permit <= 1'b1;
        four_wire_command_mode <= 1'b1;
        $display("test refusals done");
        for (int s = 0; s < 4; s++)
        begin
            cfg(3'h0, 2'(s));
            r = xs();
            rd(r[23:0], (s == 1) ? 8'h20 : 8'h00, 12);
        end
        $display("test four-wire reads done");
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        dsel <= 2'h0;
        wbits <= 3'h7;
        arm = 1'b0;
        check("wrap reset", wcur, 3'h7);
        repeat (4) @(posedge clk_in);
        rd(24'h00003c, 8'h00, 10);
        $display("test second reset done");
        finish_test();
    end
endmodule
